// [sfm_map.vh]
/*
 Register offsets, field positions, reset values and timing counts
 of the security fault monitor.
 Assumes a plain register port with word offsets and 8-bit data.
*/
`ifndef SFM_MAP_VH
`define SFM_MAP_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SFM_ADDR_W 4
`define SFM_OFF_RST_CAUSE 4'h0
`define SFM_OFF_EXC_CAUSE 4'h1
`define SFM_OFF_NVM_CTRL 4'h2
`define SFM_OFF_HV_STAT 4'h3
`define SFM_OFF_SENS_CTRL 4'h4
`define SFM_OFF_SP_USR_LIM 4'h5
`define SFM_OFF_SP_SYS_LIM 4'h6
`define SFM_OFF_SP_SSM_LIM 4'h7

// ----------------------------------------------------------------
// Reset cause bits
// ----------------------------------------------------------------
`define SFM_RC_VOLT 0
`define SFM_RC_FREQ 1
`define SFM_RC_TEMP 2
`define SFM_RC_LIGHT 3
`define SFM_RC_ROMPAR 4
`define SFM_RC_POWERON 7

// ----------------------------------------------------------------
// Exception cause bits
// ----------------------------------------------------------------
`define SFM_EC_NVM_LIGHT 0
`define SFM_EC_PC 1
`define SFM_EC_SP 2
`define SFM_EC_PSW 3
`define SFM_EC_CIPHER 4
`define SFM_EC_ARITH 5
`define SFM_EC_SP_LIMIT 6

// ----------------------------------------------------------------
// Light detection select and reset values
// ----------------------------------------------------------------
`define SFM_NVM_LD_OFF 2'h0
`define SFM_NVM_LD_FN_A 2'h1
`define SFM_NVM_LD_FN_B 2'h2
`define SFM_RST_CAUSE_RV 8'h80
`define SFM_SP_LIM_RV 8'hFF

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SFM_CLK_MHZ 100
`define SFM_RST_PULSE_NS 160
`define SFM_RST_PULSE_CYC ((`SFM_RST_PULSE_NS * `SFM_CLK_MHZ + 999) / 1000)

`endif

// [sfm_ecc_byte.v]
/*
 Single-bit correcting decoder for one non-volatile memory byte,
 a Hamming(12,8) code word with four check bits.
 Assumes the memory stores the check bits beside every data byte.
*/
`timescale 1ns/1ps
module sfm_ecc_byte (
	// Code word in
	input wire [7:0] data_i,
	input wire [3:0] chk_i,
	// Corrected byte and error flag out
	output reg [7:0] data_o,
	output wire err_o
);
	// Data bit positions inside the 12-bit Hamming word
	wire [11:0] cw;
	wire [3:0] syn;
	assign cw = {data_i[7:4], chk_i[3], data_i[3:1], chk_i[2], data_i[0],
		chk_i[1], chk_i[0]};
	// Syndrome names the flipped position, one based
	assign syn[0] = cw[0] ^ cw[2] ^ cw[4] ^ cw[6] ^ cw[8] ^ cw[10];
	assign syn[1] = cw[1] ^ cw[2] ^ cw[5] ^ cw[6] ^ cw[9] ^ cw[10];
	assign syn[2] = cw[3] ^ cw[4] ^ cw[5] ^ cw[6] ^ cw[11];
	assign syn[3] = cw[7] ^ cw[8] ^ cw[9] ^ cw[10] ^ cw[11];
	assign err_o = |syn;

	// Flip the pointed bit; flips on check bits leave data alone
	reg [11:0] fix;
	always @* begin
		fix = cw;
		if (syn != 4'h0 && syn <= 4'hC) begin
			fix[syn - 4'h1] = ~cw[syn - 4'h1];
		end
		data_o = {fix[11:8], fix[6:4], fix[2]};
	end
endmodule

// [sfm_security_fault_monitor.v]
/*
 Security fault monitor: sensor alarms to forced reset or exception,
 cause indicators, stack limit checks, NVM byte correction, ROM parity
 and programming high voltage status.
 Assumes alarms arrive asynchronously from analog sensors, the rest
 from logic on CLK_I, and that the chip reset tree follows RESET_REQ_O.
*/
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "sfm_map.vh"
module sfm_security_fault_monitor (
	// Clock and reset
	input wire CLK_I,
	input wire RST_N_I,
	// Register port
	input wire [3:0] ADDR_I,
	input wire [7:0] WDATA_I,
	input wire WR_I,
	input wire RD_I,
	output reg [7:0] RDATA_O,
	// Sensor alarms, asynchronous
	input wire VOLT_ALARM_I,
	input wire FREQ_ALARM_I,
	input wire TEMP_ALARM_I,
	input wire LIGHT_ALARM_I,
	// Fault-injection detectors, same clock
	input wire PC_FAULT_I,
	input wire SP_FAULT_I,
	input wire PSW_FAULT_I,
	input wire CIPHER_FAULT_I,
	input wire ARITH_FAULT_I,
	// CPU mode and stack pointers
	input wire TEST_MODE_I,
	input wire [1:0] CPU_MODE_I,
	input wire [7:0] SP_USR_I,
	input wire [7:0] SP_SYS_I,
	input wire [7:0] SP_SSM_I,
	// NVM read path and light detectors
	input wire NVM_RD_I,
	input wire [7:0] NVM_DATA_I,
	input wire [3:0] NVM_CHK_I,
	input wire NVM_LIGHT_A_I,
	input wire NVM_LIGHT_B_I,
	// NVM write high voltage sensor
	input wire NVM_WR_BUSY_I,
	input wire HV_OK_I,
	// Mask ROM read path
	input wire ROM_RD_I,
	input wire [7:0] ROM_DATA_I,
	input wire ROM_PAR_I,
	// Outputs
	output reg RESET_REQ_O,
	output reg EXC_O,
	output reg SENS_EN_O,
	output reg [1:0] NVM_LD_SEL_O,
	output reg [7:0] NVM_RDATA_O,
	output reg NVM_RVALID_O,
	output reg NVM_CORR_O
);
	localparam MODE_USR = 2'h0;
	localparam MODE_SYS = 2'h1;
	localparam ST_RUN = 1'b0;
	localparam ST_RST = 1'b1;
	localparam integer RST_CYC_I = `SFM_RST_PULSE_CYC;
	localparam [7:0] RST_CYC = RST_CYC_I[7:0];

	// ------------------------------------------------------------
	// Alarm synchronisers
	// ------------------------------------------------------------
	// Three stages; a change counts once stages two and three agree
	wire [3:0] alarm_raw;
	reg [3:0] s1_ff;
	reg [3:0] s2_ff;
	reg [3:0] s3_ff;
	reg [3:0] alarm_ff;
	assign alarm_raw = {LIGHT_ALARM_I, TEMP_ALARM_I, FREQ_ALARM_I,
		VOLT_ALARM_I};
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_sync
			// Filtered level per sensor
			always @(posedge CLK_I or negedge RST_N_I) begin
				if (!RST_N_I) begin
					s1_ff[g] <= 1'b0;
					s2_ff[g] <= 1'b0;
					s3_ff[g] <= 1'b0;
					alarm_ff[g] <= 1'b0;
				end else begin
					s1_ff[g] <= alarm_raw[g];
					s2_ff[g] <= s1_ff[g];
					s3_ff[g] <= s2_ff[g];
					if (s2_ff[g] == s3_ff[g]) begin
						alarm_ff[g] <= s3_ff[g];
					end
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Sensor enable and light function select
	// ------------------------------------------------------------
	// Sensors follow the mode only; the control register ignores writes
	// so a glitched store cannot turn them off.
	wire sens_en;
	assign sens_en = ~TEST_MODE_I;
	reg [1:0] nvm_ld_ff;
	reg [1:0] nxt_nvm_ld;
	always @* begin
		nxt_nvm_ld = nvm_ld_ff;
		if (WR_I && ADDR_I == `SFM_OFF_NVM_CTRL) begin
			// Unused code 3 means off, so at most one function runs
			if (WDATA_I[1:0] == `SFM_NVM_LD_FN_A ||
				WDATA_I[1:0] == `SFM_NVM_LD_FN_B) begin
				nxt_nvm_ld = WDATA_I[1:0];
			end else begin
				nxt_nvm_ld = `SFM_NVM_LD_OFF;
			end
		end
	end

	// ------------------------------------------------------------
	// Stack limit registers and checks
	// ------------------------------------------------------------
	reg [7:0] sp_lim_ff [0:2];
	wire [2:0] sp_hit;
	wire [7:0] sp_cur [0:2];
	wire [1:0] mode_idx;
	assign sp_cur[0] = SP_USR_I;
	assign sp_cur[1] = SP_SYS_I;
	assign sp_cur[2] = SP_SSM_I;
	assign mode_idx = (CPU_MODE_I == MODE_USR) ? 2'd0 :
		(CPU_MODE_I == MODE_SYS) ? 2'd1 : 2'd2;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_stack
			// One limit and comparator per privilege level
			always @(posedge CLK_I or negedge RST_N_I) begin
				if (!RST_N_I) begin
					sp_lim_ff[g] <= `SFM_SP_LIM_RV;
				end else if (WR_I &&
					ADDR_I == `SFM_OFF_SP_USR_LIM + g[3:0]) begin
					sp_lim_ff[g] <= WDATA_I;
				end
			end
			// Only the active mode's pointer can fault
			assign sp_hit[g] = (mode_idx == g[1:0]) &&
				(sp_cur[g] >= sp_lim_ff[g]);
		end
	endgenerate

	// ------------------------------------------------------------
	// Integrity checks on memory reads
	// ------------------------------------------------------------
	wire [7:0] nvm_fixed;
	wire nvm_err;
	sfm_ecc_byte u_ecc (
		.data_i(NVM_DATA_I),
		.chk_i(NVM_CHK_I),
		.data_o(nvm_fixed),
		.err_o(nvm_err)
	);
	// Odd parity over data and parity bit
	wire rom_par_err;
	assign rom_par_err = ROM_RD_I & ~(^{ROM_DATA_I, ROM_PAR_I});

	// ------------------------------------------------------------
	// Event classification, hard wired
	// ------------------------------------------------------------
	// Fixed wiring: no register bit reaches rst_src; the light select and stack limits reach exc_src
	wire [7:0] rst_src;
	wire [7:0] exc_src;
	wire nvm_light;
	assign nvm_light =
		(nvm_ld_ff == `SFM_NVM_LD_FN_A && NVM_LIGHT_A_I) ||
		(nvm_ld_ff == `SFM_NVM_LD_FN_B && NVM_LIGHT_B_I);
	assign rst_src = {3'b000, rom_par_err,
		alarm_ff & {4{sens_en}}};
	assign exc_src = {1'b0, |sp_hit, ARITH_FAULT_I, CIPHER_FAULT_I,
		PSW_FAULT_I, SP_FAULT_I, PC_FAULT_I,
		nvm_light & sens_en};

	// ------------------------------------------------------------
	// Reset sequencer
	// ------------------------------------------------------------
	// The cause survives the forced reset because this block sits on
	// RST_N_I only; RESET_REQ_O resets the rest of the chip.
	reg st_ff;
	reg nxt_st;
	reg [7:0] cnt_ff;
	reg [7:0] nxt_cnt;
	reg [7:0] rst_cause_ff;
	reg [7:0] nxt_rst_cause;
	always @* begin
		nxt_st = st_ff;
		nxt_cnt = cnt_ff;
		nxt_rst_cause = rst_cause_ff;
		case (st_ff)
			ST_RUN: begin
				if (|rst_src) begin
					nxt_st = ST_RST;
					nxt_cnt = RST_CYC;
					nxt_rst_cause = rst_src;
				end
			end
			ST_RST: begin
				// Hold while the alarm lasts, then a full pulse
				if (|rst_src) begin
					nxt_cnt = RST_CYC;
				end else if (cnt_ff == 8'h01) begin
					nxt_st = ST_RUN;
				end else begin
					nxt_cnt = cnt_ff - 8'h01;
				end
			end
			default: begin
				nxt_st = ST_RUN;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Exception cause capture
	// ------------------------------------------------------------
	// New events overwrite the cause; a forced reset clears it
	reg [7:0] exc_cause_ff;
	reg [7:0] nxt_exc_cause;
	reg hv_fail_ff;
	reg hv_busy_d_ff;
	always @* begin
		nxt_exc_cause = exc_cause_ff;
		if (st_ff == ST_RST) begin
			nxt_exc_cause = 8'h00;
		end else if (|exc_src) begin
			nxt_exc_cause = exc_src;
		end
	end

	// ------------------------------------------------------------
	// State registers
	// ------------------------------------------------------------
	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			st_ff <= ST_RUN;
			cnt_ff <= 8'h00;
			rst_cause_ff <= `SFM_RST_CAUSE_RV;
			exc_cause_ff <= 8'h00;
			nvm_ld_ff <= `SFM_NVM_LD_OFF;
			hv_fail_ff <= 1'b0;
			RESET_REQ_O <= 1'b0;
			EXC_O <= 1'b0;
			SENS_EN_O <= 1'b0;
			NVM_LD_SEL_O <= `SFM_NVM_LD_OFF;
			NVM_RDATA_O <= 8'h00;
			NVM_RVALID_O <= 1'b0;
			NVM_CORR_O <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			cnt_ff <= nxt_cnt;
			rst_cause_ff <= nxt_rst_cause;
			exc_cause_ff <= nxt_exc_cause;
			nvm_ld_ff <= (st_ff == ST_RST) ? `SFM_NVM_LD_OFF : nxt_nvm_ld;
			RESET_REQ_O <= (nxt_st == ST_RST);
			// Exception flag one cycle after each event cycle, none while st_ff is ST_RST
			EXC_O <= (|exc_src) && (st_ff == ST_RUN);
			SENS_EN_O <= sens_en;
			NVM_LD_SEL_O <= nvm_ld_ff;
			// Corrected byte, one cycle after the read strobe
			NVM_RDATA_O <= nvm_fixed;
			NVM_RVALID_O <= NVM_RD_I;
			NVM_CORR_O <= NVM_RD_I & nvm_err;
			// Sample the sensor while programming; never an event.
			// A new write sequence drops the stale result of the last one.
			if (NVM_WR_BUSY_I && !hv_busy_d_ff) begin
				hv_fail_ff <= ~HV_OK_I;
			end else if (NVM_WR_BUSY_I) begin
				hv_fail_ff <= hv_fail_ff | ~HV_OK_I;
			end
		end
	end

	// ------------------------------------------------------------
	// Register read port
	// ------------------------------------------------------------
	// Delayed busy marks the cycle in which a write sequence ends
	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			hv_busy_d_ff <= 1'b0;
			RDATA_O <= 8'h00;
		end else begin
			hv_busy_d_ff <= NVM_WR_BUSY_I;
			RDATA_O <= 8'h00;
			if (RD_I) begin
				case (ADDR_I)
					`SFM_OFF_RST_CAUSE: RDATA_O <= rst_cause_ff;
					`SFM_OFF_EXC_CAUSE: RDATA_O <= exc_cause_ff;
					`SFM_OFF_NVM_CTRL: RDATA_O <= {6'h00, nvm_ld_ff};
					`SFM_OFF_HV_STAT: RDATA_O <= {5'h00, NVM_WR_BUSY_I,
						hv_busy_d_ff & ~NVM_WR_BUSY_I, hv_fail_ff};
					`SFM_OFF_SENS_CTRL: RDATA_O <= {7'h00, sens_en};
					`SFM_OFF_SP_USR_LIM: RDATA_O <= sp_lim_ff[0];
					`SFM_OFF_SP_SYS_LIM: RDATA_O <= sp_lim_ff[1];
					`SFM_OFF_SP_SSM_LIM: RDATA_O <= sp_lim_ff[2];
					default: RDATA_O <= 8'h00;
				endcase
			end
		end
	end
endmodule

// [sfm_props.sv]
/*
 Checker for the security fault monitor, watching top-level ports only.
 Assumes one clock domain and the bind placed after the module.
*/
`timescale 1ns/1ps
module sfm_props (
	// Clock and reset
	input wire CLK_I,
	input wire RST_N_I,
	// Event sources
	input wire VOLT_ALARM_I,
	input wire FREQ_ALARM_I,
	input wire TEMP_ALARM_I,
	input wire LIGHT_ALARM_I,
	input wire PC_FAULT_I,
	input wire SP_FAULT_I,
	input wire PSW_FAULT_I,
	input wire CIPHER_FAULT_I,
	input wire ARITH_FAULT_I,
	input wire TEST_MODE_I,
	input wire NVM_RD_I,
	input wire ROM_RD_I,
	input wire [7:0] ROM_DATA_I,
	input wire ROM_PAR_I,
	// Responses
	input wire RESET_REQ_O,
	input wire EXC_O,
	input wire SENS_EN_O,
	input wire [1:0] NVM_LD_SEL_O,
	input wire NVM_RVALID_O
);
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	// Merged sources keep the properties short
	wire flt = PC_FAULT_I | SP_FAULT_I | PSW_FAULT_I | CIPHER_FAULT_I |
		ARITH_FAULT_I;
	wire alm = VOLT_ALARM_I | FREQ_ALARM_I | TEMP_ALARM_I | LIGHT_ALARM_I;
	wire par_bad = ROM_RD_I & ~(^{ROM_DATA_I, ROM_PAR_I});
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!RST_N_I);
	a_alarm_forces_rst: assert property (
		(alm && !TEST_MODE_I) [*5] |=> RESET_REQ_O)
		else $error("sensor alarm gave no reset");
	a_fault_gives_exc: assert property (
		flt && !RESET_REQ_O |=> EXC_O)
		else $error("fault gave no exception");
	a_exc_blocked_rst: assert property (
		RESET_REQ_O ##1 RESET_REQ_O |-> !EXC_O)
		else $error("exception during forced reset");
	a_rom_par_rst: assert property (
		par_bad |=> RESET_REQ_O)
		else $error("parity error gave no reset");
	a_rst_min_len: assert property (
		$rose(RESET_REQ_O) |-> ##15 RESET_REQ_O)
		else $error("forced reset too short");
	a_sens_on_run: assert property (
		!TEST_MODE_I ##1 !TEST_MODE_I |=> SENS_EN_O)
		else $error("sensors off outside test mode");
	a_sens_off_test: assert property (
		TEST_MODE_I |=> !SENS_EN_O)
		else $error("sensors on in test mode");
	a_nvm_valid: assert property (
		NVM_RD_I |=> NVM_RVALID_O)
		else $error("no read valid after read");
	a_ld_sel_legal: assert property (
		NVM_LD_SEL_O != 2'h3)
		else $error("both light functions selected");
endmodule

bind sfm_security_fault_monitor sfm_props i_sfm_props (
	.CLK_I(CLK_I), .RST_N_I(RST_N_I), .VOLT_ALARM_I(VOLT_ALARM_I),
	.FREQ_ALARM_I(FREQ_ALARM_I), .TEMP_ALARM_I(TEMP_ALARM_I),
	.LIGHT_ALARM_I(LIGHT_ALARM_I), .PC_FAULT_I(PC_FAULT_I),
	.SP_FAULT_I(SP_FAULT_I), .PSW_FAULT_I(PSW_FAULT_I),
	.CIPHER_FAULT_I(CIPHER_FAULT_I), .ARITH_FAULT_I(ARITH_FAULT_I),
	.TEST_MODE_I(TEST_MODE_I), .NVM_RD_I(NVM_RD_I), .ROM_RD_I(ROM_RD_I),
	.ROM_DATA_I(ROM_DATA_I), .ROM_PAR_I(ROM_PAR_I),
	.RESET_REQ_O(RESET_REQ_O), .EXC_O(EXC_O), .SENS_EN_O(SENS_EN_O),
	.NVM_LD_SEL_O(NVM_LD_SEL_O), .NVM_RVALID_O(NVM_RVALID_O)
);

// [tb.sv]
/*
 Self-checking bench for the security fault monitor.
 Assumes the register map header and the checker bound to the design.
*/
`timescale 1ns/1ps
`include "sfm_map.vh"
module tb;
	// ----------------------------------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------------------------------
	reg clk = 0, rst_n = 0, wr_s = 0, rd_s = 0, tm = 0, nrd = 0;
	reg la = 0, lb = 0, wbusy = 0, hvok = 1, rrd = 0, rpar = 1;
	reg [3:0] addr = 0, alm = 0, nc = 0;
	reg [4:0] flt = 0;
	reg [1:0] mode = 0;
	reg [7:0] wdat = 0, sp_u = 0, sp_s = 0, sp_m = 0, nd = 0, rdat = 0;
	reg [12:0] row [0:4];
	wire [7:0] rdata, nrdata;
	wire [1:0] ldsel;
	wire rreq, exc, sen, nvld, ncor;
	integer compares = 0, bad_count = 0, cyc = 0, cnt, i;
	// Clock at 100 MHz
	always #5 clk = ~clk;
	sfm_security_fault_monitor i_sfm_security_fault_monitor (
		.CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdat),
		.WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata), .VOLT_ALARM_I(alm[0]),
		.FREQ_ALARM_I(alm[1]), .TEMP_ALARM_I(alm[2]),
		.LIGHT_ALARM_I(alm[3]), .PC_FAULT_I(flt[0]), .SP_FAULT_I(flt[1]),
		.PSW_FAULT_I(flt[2]), .CIPHER_FAULT_I(flt[3]),
		.ARITH_FAULT_I(flt[4]), .TEST_MODE_I(tm), .CPU_MODE_I(mode),
		.SP_USR_I(sp_u), .SP_SYS_I(sp_s), .SP_SSM_I(sp_m), .NVM_RD_I(nrd),
		.NVM_DATA_I(nd), .NVM_CHK_I(nc), .NVM_LIGHT_A_I(la),
		.NVM_LIGHT_B_I(lb), .NVM_WR_BUSY_I(wbusy), .HV_OK_I(hvok),
		.ROM_RD_I(rrd), .ROM_DATA_I(rdat), .ROM_PAR_I(rpar),
		.RESET_REQ_O(rreq), .EXC_O(exc), .SENS_EN_O(sen),
		.NVM_LD_SEL_O(ldsel), .NVM_RDATA_O(nrdata), .NVM_RVALID_O(nvld),
		.NVM_CORR_O(ncor)
	);
	// ----------------------------------------------------------------
	// Tasks: each one that waits ends 1 ns after an edge, outputs settled
	// ----------------------------------------------------------------
	task chk(input [63:0] nm, input [7:0] got, input [7:0] exp);
		begin
			compares = compares + 1;
			if (got !== exp) begin
				bad_count = bad_count + 1;
				$display("CHECK FAILED %0s exp %h got %h", nm, exp, got);
			end
		end
	endtask
	task end_sim;
		begin
			$display("compares %0d bad_count %0d", compares, bad_count);
			if (bad_count == 0 && compares > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	task tick(input integer n);
		begin
			repeat (n) @(posedge clk);
			#1;
		end
	endtask
	task wr(input [3:0] a, input [7:0] d);
		begin
			addr <= a;
			wdat <= d;
			wr_s <= 1'b1;
			@(posedge clk);
			wr_s <= 1'b0;
			#1;
		end
	endtask
	// Read data stand only in the cycle after the strobe
	task rd(input [3:0] a, input [7:0] m, input [7:0] exp);
		begin
			addr <= a;
			rd_s <= 1'b1;
			@(posedge clk);
			rd_s <= 1'b0;
			#1;
			chk("rdata", rdata & m, exp);
		end
	endtask
	// One-cycle pulse on {light B, light A, faults}
	task hit(input [6:0] s, input e);
		begin
			{lb, la, flt} <= s;
			tick(1);
			{lb, la, flt} <= 7'h00;
			chk("exc", exc, e);
			tick(1);
			chk("exc", exc, 1'b0);
		end
	endtask
	// Bounded wait on the reset request; cnt keeps the cycles spent
	task await(input v);
		begin
			cnt = 0;
			while (rreq !== v && cnt < 60) begin
				tick(1);
				cnt = cnt + 1;
			end
			chk("rst_req", rreq, v);
		end
	endtask
	task nvm(input [7:0] d, input [3:0] c, input [7:0] e, input cr);
		begin
			nd <= d;
			nc <= c;
			nrd <= 1'b1;
			tick(1);
			nrd <= 1'b0;
			chk("nvm_dat", nrdata, e);
			chk("nvm_cor", {nvld, ncor}, {1'b1, cr});
			tick(1);
			chk("nvm_vld", {nvld, ncor}, 2'b00);
		end
	endtask
	// Even check bits at code positions 1, 2, 4 and 8
	function [3:0] ecc(input [7:0] d);
		begin
			ecc[0] = d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6];
			ecc[1] = d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
			ecc[2] = d[1] ^ d[2] ^ d[3] ^ d[7];
			ecc[3] = d[4] ^ d[5] ^ d[6] ^ d[7];
		end
	endfunction
	// Hang guard, far above the few hundred cycles needed
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			bad_count = bad_count + 1;
			end_sim;
		end
	end
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		row[0] = {5'h01, 8'h01 << `SFM_EC_PC};
		row[1] = {5'h02, 8'h01 << `SFM_EC_SP};
		row[2] = {5'h04, 8'h01 << `SFM_EC_PSW};
		row[3] = {5'h08, 8'h01 << `SFM_EC_CIPHER};
		row[4] = {5'h10, 8'h01 << `SFM_EC_ARITH};
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		tick(1);
		rd(`SFM_OFF_RST_CAUSE, 8'hFF, `SFM_RST_CAUSE_RV);
		rd(`SFM_OFF_EXC_CAUSE, 8'hFF, 8'h00);
		for (i = 5; i < 9; i = i + 1)
			rd(i[3:0], 8'hFF, (i < 8) ? `SFM_SP_LIM_RV : 8'h00);
		wr(`SFM_OFF_RST_CAUSE, 8'h00);
		wr(`SFM_OFF_SENS_CTRL, 8'h00);
		rd(`SFM_OFF_RST_CAUSE, 8'hFF, `SFM_RST_CAUSE_RV);
		chk("sens_en", sen, 1'b1);
		rd(`SFM_OFF_SENS_CTRL, 8'hFF, 8'h01);
		// Fault rows: pulse, exception, cause read back
		for (i = 0; i < 5; i = i + 1) begin
			hit({2'b00, row[i][12:8]}, 1'b1);
			tick(3);
			rd(`SFM_OFF_EXC_CAUSE, 8'hFF, row[i][7:0]);
		end
		// Light function select: only the chosen one acts
		wr(`SFM_OFF_NVM_CTRL, {6'h00, `SFM_NVM_LD_FN_A});
		hit(7'h40, 1'b0);
		chk("ld_sel", ldsel, `SFM_NVM_LD_FN_A);
		hit(7'h20, 1'b1);
		rd(`SFM_OFF_EXC_CAUSE, 8'hFF, 8'h01 << `SFM_EC_NVM_LIGHT);
		wr(`SFM_OFF_NVM_CTRL, 8'h03);
		hit(7'h60, 1'b0);
		chk("ld_sel", ldsel, `SFM_NVM_LD_OFF);
		wr(`SFM_OFF_NVM_CTRL, {6'h00, `SFM_NVM_LD_FN_B});
		hit(7'h20, 1'b0);
		hit(7'h40, 1'b1);
		// Stack limit per level, boundary at the limit itself
		wr(`SFM_OFF_SP_USR_LIM, 8'h40);
		mode <= 2'd1;
		sp_u <= 8'h50;
		tick(2);
		chk("exc", exc, 1'b0);
		mode <= 2'd0;
		sp_u <= 8'h3F;
		tick(2);
		chk("exc", exc, 1'b0);
		sp_u <= 8'h40;
		tick(1);
		sp_u <= 8'h00;
		chk("exc", exc, 1'b1);
		rd(`SFM_OFF_EXC_CAUSE, 8'hFF, 8'h01 << `SFM_EC_SP_LIMIT);
		// Super system level, mode code 3, own limit
		wr(`SFM_OFF_SP_SSM_LIM, 8'h10);
		mode <= 2'd3;
		sp_m <= 8'h10;
		tick(1);
		sp_m <= 8'h00;
		chk("exc", exc, 1'b1);
		// Programming voltage low: status only, no event
		wbusy <= 1'b1;
		hvok <= 1'b0;
		tick(4);
		chk("hv_evt", {exc, rreq}, 2'b00);
		rd(`SFM_OFF_HV_STAT, 8'h05, 8'h05);
		wbusy <= 1'b0;
		hvok <= 1'b1;
		tick(2);
		rd(`SFM_OFF_HV_STAT, 8'h01, 8'h01);
		// Good second sequence replaces the old result
		wbusy <= 1'b1;
		tick(2);
		wbusy <= 1'b0;
		rd(`SFM_OFF_HV_STAT, 8'h07, 8'h02);
		// Byte correction: clean word, then one data bit flipped
		nvm(8'hA5, ecc(8'hA5), 8'hA5, 1'b0);
		nvm(8'hA1, ecc(8'hA5), 8'hA5, 1'b1);
		// ROM read: good parity, then a parity error
		rrd <= 1'b1;
		rdat <= 8'h01;
		rpar <= 1'b0;
		tick(1);
		chk("rst_req", rreq, 1'b0);
		rpar <= 1'b1;
		tick(1);
		rrd <= 1'b0;
		chk("rst_req", rreq, 1'b1);
		await(1'b0);
		chk("rst_len", cnt[7:0], 8'd16);
		rd(`SFM_OFF_RST_CAUSE, 8'hFF, 8'h01 << `SFM_RC_ROMPAR);
		rd(`SFM_OFF_EXC_CAUSE, 8'hFF, 8'h00);
		// Each sensor alarm forces reset, never an exception
		for (i = 0; i < 4; i = i + 1) begin
			alm <= 4'h1 << i;
			await(1'b1);
			chk("exc", exc, 1'b0);
			alm <= 4'h0;
			await(1'b0);
			rd(`SFM_OFF_RST_CAUSE, 8'hFF, 8'h01 << i);
		end
		// Test mode: sensors off, alarms ignored
		tm <= 1'b1;
		alm <= 4'hF;
		tick(10);
		chk("tm_out", {sen, rreq}, 2'b00);
		alm <= 4'h0;
		tick(8);
		tm <= 1'b0;
		tick(2);
		chk("sens_en", sen, 1'b1);
		// Second reset mid-run returns defaults
		wr(`SFM_OFF_NVM_CTRL, {6'h00, `SFM_NVM_LD_FN_A});
		hit(7'h01, 1'b1);
		chk("ld_sel", ldsel, `SFM_NVM_LD_FN_A);
		rst_n <= 1'b0;
		tick(3);
		rst_n <= 1'b1;
		tick(1);
		chk("ld_sel", ldsel, `SFM_NVM_LD_OFF);
		rd(`SFM_OFF_RST_CAUSE, 8'hFF, `SFM_RST_CAUSE_RV);
		rd(`SFM_OFF_EXC_CAUSE, 8'hFF, 8'h00);
		rd(`SFM_OFF_SP_USR_LIM, 8'hFF, `SFM_SP_LIM_RV);
		end_sim;
	end
endmodule
